// ### hw/tfp_pkg.sv
package tfp_pkg;
  localparam int NUM_CHAN = 6;
  localparam int NUM_TRIG_CHAN = 4;
  localparam int NUM_EXT_TRIG = 16;
  // Register byte offsets
  localparam logic [7:0] STATUS_OFFSET = 8'h50;
  localparam logic [7:0] POLARITY_OFFSET = 8'h70;
  localparam logic [7:0] CONFIG_OFFSET = 8'h84;
  // Combined status word layout
  localparam int STAT_CHAN_LSB = 0;
  localparam int STAT_OVF_BIT = 8;
  // Configuration field positions
  localparam int CFG_SEL_LSB = 24;
  localparam int CFG_SEL_W = 4;
  localparam int CFG_SRC_BIT = 23;
  localparam int CFG_TPOL_BIT = 22;
  localparam int CFG_PAUSE_BIT = 19;
  localparam int CFG_RELOAD_BIT = 18;
  localparam int CFG_START_BIT = 16;
  // Values after reset
  localparam logic [5:0] POLARITY_RESET = 6'h00;
  localparam logic [3:0] SEL_RESET = 4'h0;
  localparam logic CFG_BIT_RESET = 1'b0;
  // Trigger source codes
  localparam logic SRC_EXTERNAL = 1'b0;
  localparam logic SRC_INTERNAL = 1'b1;
endpackage : tfp_pkg

// ### hw/tfp_flag.sv
`timescale 1ns/1ps
module tfp_flag (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Set and clear
  input wire logic set_in,
  input wire logic clear_in,
  // State
  output logic flag_out
);
  // Set wins over a clear landing in the same cycle
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      flag_out <= 1'b0;
    end else if (set_in) begin
      flag_out <= 1'b1;
    end else if (clear_in) begin
      flag_out <= 1'b0;
    end
  end

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  a_flag_sticky_set: assert property (
    set_in ##1 !clear_in [*3] |-> flag_out && $past(flag_out) && $past(flag_out, 2))
    else $error("flag did not stay set after event");
  a_clear_one_only: assert property (
    clear_in && !set_in |=> !flag_out)
    else $error("clearing write did not clear flag");
  a_event_beats_clear: assert property (
    set_in && clear_in |=> flag_out)
    else $error("clear overrode a new event");
endmodule : tfp_flag

// ### hw/tfp_core.sv
`timescale 1ns/1ps
module tfp_core #(
  parameter int NUM_CHAN = tfp_pkg::NUM_CHAN,
  parameter int NUM_EXT_TRIG = tfp_pkg::NUM_EXT_TRIG
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Channel and counter events
  input wire logic [NUM_CHAN-1:0] chan_event_in,
  input wire logic [NUM_CHAN-1:0] chan_home_clear_in,
  input wire logic overflow_event_in,
  input wire logic overflow_home_clear_in,
  output logic [NUM_CHAN-1:0] channel_event_flag_out,
  output logic counter_overflow_flag_out,
  // Trigger inputs
  input wire logic [NUM_CHAN-1:0] chan_pin_in,
  input wire logic [NUM_EXT_TRIG-1:0] ext_trigger_in,
  // Counter control
  input wire logic counter_enable_in,
  input wire logic mode_pause_in,
  output logic [NUM_CHAN-1:0] channel_polarity_out,
  output logic counter_start_out,
  output logic counter_reload_out,
  output logic counter_pause_out,
  output logic count_permit_out
);
  localparam int TC = tfp_pkg::NUM_TRIG_CHAN;

  logic [NUM_CHAN-1:0] channel_polarity_bit;
  logic [3:0] trigger_select;
  logic trigger_source_select;
  logic trigger_polarity;
  logic pause_on_trigger;
  logic reload_on_trigger;
  logic start_on_trigger;
  logic setup_phase;
  logic write_strobe;
  logic sel_status;
  logic sel_polarity;
  logic sel_config;
  logic mapped;
  logic [31:0] status_word;
  logic [31:0] config_word;
  logic [31:0] next_rdata;
  logic [NUM_CHAN-1:0] pin_eff;
  logic [NUM_CHAN-1:0] pin_prev;
  logic [TC-1:0] chan_mask;
  logic int_level;
  logic int_rise;
  logic int_any_edge;
  logic ext_level;
  logic ext_prev;
  logic ext_rise;
  logic trig_level;
  logic trig_rise;
  logic reload_edge;
  logic started;
  logic [NUM_CHAN-1:0] chan_clear;
  logic ovf_clear;

  // Bus decode
  assign setup_phase = psel && !penable;
  assign write_strobe = psel && penable && pwrite && mapped;
  assign sel_status = paddr == tfp_pkg::STATUS_OFFSET;
  assign sel_polarity = paddr == tfp_pkg::POLARITY_OFFSET;
  assign sel_config = paddr == tfp_pkg::CONFIG_OFFSET;
  assign mapped = sel_status || sel_polarity || sel_config;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Register images, reserved bits zero
  always_comb begin
    status_word = 32'h00000000;
    status_word[tfp_pkg::STAT_CHAN_LSB +: NUM_CHAN] = channel_event_flag_out;
    status_word[tfp_pkg::STAT_OVF_BIT] = counter_overflow_flag_out;
  end

  always_comb begin
    config_word = 32'h00000000;
    config_word[tfp_pkg::CFG_SEL_LSB +: tfp_pkg::CFG_SEL_W] = trigger_select;
    config_word[tfp_pkg::CFG_SRC_BIT] = trigger_source_select;
    config_word[tfp_pkg::CFG_TPOL_BIT] = trigger_polarity;
    config_word[tfp_pkg::CFG_PAUSE_BIT] = pause_on_trigger;
    config_word[tfp_pkg::CFG_RELOAD_BIT] = reload_on_trigger;
    config_word[tfp_pkg::CFG_START_BIT] = start_on_trigger;
  end

  always_comb begin
    next_rdata = 32'h00000000;
    if (sel_status) begin
      next_rdata = status_word;
    end else if (sel_polarity) begin
      next_rdata[NUM_CHAN-1:0] = channel_polarity_bit;
    end else if (sel_config) begin
      next_rdata = config_word;
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      prdata <= 32'h00000000;
    end else if (setup_phase && !pwrite) begin
      prdata <= next_rdata;
    end
  end

  // Polarity register
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      channel_polarity_bit <= tfp_pkg::POLARITY_RESET;
    end else if (write_strobe && sel_polarity) begin
      channel_polarity_bit <= pwdata[NUM_CHAN-1:0];
    end
  end
  assign channel_polarity_out = channel_polarity_bit;

  // Trigger configuration fields
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      trigger_select <= tfp_pkg::SEL_RESET;
      trigger_source_select <= tfp_pkg::CFG_BIT_RESET;
      trigger_polarity <= tfp_pkg::CFG_BIT_RESET;
      pause_on_trigger <= tfp_pkg::CFG_BIT_RESET;
      reload_on_trigger <= tfp_pkg::CFG_BIT_RESET;
      start_on_trigger <= tfp_pkg::CFG_BIT_RESET;
    end else if (write_strobe && sel_config) begin
      trigger_select <= pwdata[tfp_pkg::CFG_SEL_LSB +: tfp_pkg::CFG_SEL_W];
      trigger_source_select <= pwdata[tfp_pkg::CFG_SRC_BIT];
      trigger_polarity <= pwdata[tfp_pkg::CFG_TPOL_BIT];
      pause_on_trigger <= pwdata[tfp_pkg::CFG_PAUSE_BIT];
      reload_on_trigger <= pwdata[tfp_pkg::CFG_RELOAD_BIT];
      start_on_trigger <= pwdata[tfp_pkg::CFG_START_BIT];
    end
  end

  // Flags, one sticky cell each
  assign chan_clear = chan_home_clear_in | ({NUM_CHAN{write_strobe && sel_status}}
    & pwdata[tfp_pkg::STAT_CHAN_LSB +: NUM_CHAN]);
  assign ovf_clear = overflow_home_clear_in
    || (write_strobe && sel_status && pwdata[tfp_pkg::STAT_OVF_BIT]);

  for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan_flag
    tfp_flag u_flag (
      .clk_sys_in(clk_sys_in),
      .sys_rst_in(sys_rst_in),
      .set_in(chan_event_in[i]),
      .clear_in(chan_clear[i]),
      .flag_out(channel_event_flag_out[i])
    );
  end

  tfp_flag u_ovf_flag (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .set_in(overflow_event_in),
    .clear_in(ovf_clear),
    .flag_out(counter_overflow_flag_out)
  );

  // Internal trigger from polarity-adjusted pins
  assign pin_eff = chan_pin_in ^ channel_polarity_bit;
  assign chan_mask = trigger_select[TC-1:0];
  assign int_level = |(pin_eff[TC-1:0] & chan_mask);
  assign int_rise = |(pin_eff[TC-1:0] & ~pin_prev[TC-1:0] & chan_mask);
  assign int_any_edge = |((pin_eff[TC-1:0] ^ pin_prev[TC-1:0]) & chan_mask);

  // External trigger
  assign ext_level = ext_trigger_in[trigger_select] ^ trigger_polarity;
  assign ext_rise = ext_level && !ext_prev;

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      pin_prev <= '0;
      ext_prev <= 1'b0;
    end else begin
      pin_prev <= pin_eff;
      ext_prev <= ext_level;
    end
  end

  // Source choice and debug/doze gating
  always_comb begin
    if (trigger_source_select == tfp_pkg::SRC_INTERNAL) begin
      trig_level = int_level;
      trig_rise = int_rise;
      reload_edge = int_any_edge;
    end else begin
      trig_level = ext_level;
      trig_rise = ext_rise;
      reload_edge = ext_rise;
    end
  end

  assign counter_start_out = start_on_trigger && trig_rise && !mode_pause_in;
  assign counter_reload_out = reload_on_trigger && reload_edge && !mode_pause_in;
  assign counter_pause_out = pause_on_trigger && trig_level && !mode_pause_in;

  // Start gate: rearmed whenever the counter is disabled
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      started <= 1'b0;
    end else if (!counter_enable_in) begin
      started <= 1'b0;
    end else if (counter_start_out) begin
      started <= 1'b1;
    end
  end

  assign count_permit_out = counter_enable_in && !counter_pause_out
    && (!start_on_trigger || started || counter_start_out);

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  a_status_read_mirror: assert property (
    setup_phase && !pwrite && sel_status |=>
      prdata[tfp_pkg::STAT_OVF_BIT] == $past(counter_overflow_flag_out)
      && prdata[NUM_CHAN-1:0] == $past(channel_event_flag_out))
    else $error("status read does not mirror flags");
  a_reserved_read_zero: assert property (
    setup_phase && !pwrite |=> prdata[31:28] == 4'h0 && prdata[21:20] == 2'h0
      && (!$past(sel_status) || (prdata[7:6] == 2'h0 && prdata[31:9] == 23'h0)))
    else $error("reserved bits read nonzero");
  a_polarity_write: assert property (
    write_strobe && sel_polarity |=> channel_polarity_out == $past(pwdata[NUM_CHAN-1:0]))
    else $error("polarity write not stored");
  a_ovf_w1c_clear: assert property (
    write_strobe && sel_status && pwdata[tfp_pkg::STAT_OVF_BIT] && !overflow_event_in
      |=> !counter_overflow_flag_out)
    else $error("overflow not cleared by status write");
  a_chan_w1c_mask: assert property (
    write_strobe && sel_status && !(|chan_event_in) && !(|chan_home_clear_in)
      |=> channel_event_flag_out == ($past(channel_event_flag_out) & ~$past(pwdata[5:0])))
    else $error("status write cleared wrong channel flags");
  a_internal_mask: assert property (
    trigger_source_select && pause_on_trigger && !mode_pause_in
      && !(|(pin_eff[TC-1:0] & trigger_select[TC-1:0])) |-> !counter_pause_out)
    else $error("pause from unselected channel");
  a_pause_level: assert property (
    counter_pause_out |-> !count_permit_out)
    else $error("counter permitted while paused by trigger");
  a_start_gate: assert property (
    $rose(counter_enable_in) && start_on_trigger && !counter_start_out
      ##1 !counter_start_out |-> !count_permit_out)
    else $error("counter ran before start trigger");
  a_reload_rise: assert property (
    reload_on_trigger && !trigger_source_select && !mode_pause_in
      && $rose(ext_level) |-> counter_reload_out)
    else $error("external rise did not reload");
  a_debug_ignore: assert property (
    mode_pause_in |-> !counter_start_out && !counter_reload_out && !counter_pause_out)
    else $error("trigger acted during debug or doze pause");
  a_pol_read_zero: assert property (
    setup_phase && !pwrite && sel_polarity |=> prdata[31:NUM_CHAN] == '0)
    else $error("polarity reserved bits read nonzero");
  a_unmapped_no_write: assert property (
    psel && penable && pwrite && !mapped |=> $stable(channel_polarity_out)
      && $stable(config_word))
    else $error("write to unmapped address changed a register");
  a_int_rise_start: assert property (
    start_on_trigger && trigger_source_select && !mode_pause_in && trigger_select[0]
      && $rose(pin_eff[0]) |-> counter_start_out)
    else $error("internal rise did not start counter");
  a_int_fall_reload: assert property (
    reload_on_trigger && trigger_source_select && !mode_pause_in && trigger_select[0]
      && !$past(sys_rst_in) && $fell(pin_eff[0]) |-> counter_reload_out)
    else $error("internal fall did not reload counter");
  a_ovf_home_clear: assert property (
    overflow_home_clear_in && !overflow_event_in |=> !counter_overflow_flag_out)
    else $error("overflow home clear did not clear flag");
  a_ext_pol_pause: assert property (
    pause_on_trigger && !trigger_source_select && !mode_pause_in
      && ext_trigger_in[trigger_select] == !trigger_polarity |-> counter_pause_out)
    else $error("external trigger level ignored polarity");
endmodule : tfp_core

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [5:0] chan_event_in = 6'h00;
  logic [5:0] chan_home_clear_in = 6'h00;
  logic overflow_event_in = 1'b0;
  logic overflow_home_clear_in = 1'b0;
  logic [5:0] channel_event_flag_out;
  logic counter_overflow_flag_out;
  logic [5:0] chan_pin_in = 6'h00;
  logic [15:0] ext_trigger_in = 16'h0000;
  logic counter_enable_in = 1'b0;
  logic mode_pause_in = 1'b0;
  logic [5:0] channel_polarity_out;
  logic counter_start_out;
  logic counter_reload_out;
  logic counter_pause_out;
  logic count_permit_out;
  logic [31:0] rd;
  logic err;
  int failures = 0;
  int n_compared = 0;

  tfp_core u_dut (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan_event_in(chan_event_in), .chan_home_clear_in(chan_home_clear_in),
    .overflow_event_in(overflow_event_in), .overflow_home_clear_in(overflow_home_clear_in),
    .channel_event_flag_out(channel_event_flag_out),
    .counter_overflow_flag_out(counter_overflow_flag_out),
    .chan_pin_in(chan_pin_in), .ext_trigger_in(ext_trigger_in),
    .counter_enable_in(counter_enable_in), .mode_pause_in(mode_pause_in),
    .channel_polarity_out(channel_polarity_out), .counter_start_out(counter_start_out),
    .counter_reload_out(counter_reload_out), .counter_pause_out(counter_pause_out),
    .count_permit_out(count_permit_out)
  );

  initial begin
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  task stop_test;
    if (failures == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // One APB transfer; waits for pready under a bound
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    check(nm, rd, e);
  endtask : rchk

  initial begin
    repeat (6) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    // Reset values and reserved bits
    rchk("pol_rst", tfp_pkg::POLARITY_OFFSET, 32'h00000000);
    rchk("cfg_rst", tfp_pkg::CONFIG_OFFSET, 32'h00000000);
    rchk("stat_rst", tfp_pkg::STATUS_OFFSET, 32'h00000000);
    wr(tfp_pkg::POLARITY_OFFSET, 32'hFFFFFFFF);
    rchk("pol_mask", tfp_pkg::POLARITY_OFFSET, 32'h0000003F);
    check("pol_out", channel_polarity_out, 6'h3F);
    wr(tfp_pkg::POLARITY_OFFSET, 32'h00000000);
    wr(tfp_pkg::CONFIG_OFFSET, 32'hFFFFFFFF);
    rchk("cfg_mask", tfp_pkg::CONFIG_OFFSET, 32'h0FCD0000);
    apb(1'b0, 8'h40, 32'h00000000);
    check("unmapped_rd", rd, 32'h00000000);
    check("unmapped_err", err, 1'b1);
    wr(8'h40, 32'hFFFFFFFF);
    rchk("unmapped_wr", tfp_pkg::CONFIG_OFFSET, 32'h0FCD0000);
    // Flags set, mirrored and cleared
    @(posedge clk_sys_in);
    chan_event_in <= 6'h3F;
    overflow_event_in <= 1'b1;
    @(posedge clk_sys_in);
    chan_event_in <= 6'h00;
    overflow_event_in <= 1'b0;
    rchk("stat_all", tfp_pkg::STATUS_OFFSET, 32'h0000013F);
    wr(tfp_pkg::STATUS_OFFSET, 32'hFFFFFEC5);
    rchk("stat_w1c", tfp_pkg::STATUS_OFFSET, 32'h0000013A);
    wr(tfp_pkg::STATUS_OFFSET, 32'h00000100);
    check("ovf_clr", counter_overflow_flag_out, 1'b0);
    check("chan_keep", channel_event_flag_out, 6'h3A);
    // Event at the clearing edge keeps its flag
    fork
      wr(tfp_pkg::STATUS_OFFSET, 32'h0000003F);
      begin
        repeat (2) @(posedge clk_sys_in);
        chan_event_in <= 6'h02;
        @(posedge clk_sys_in);
        chan_event_in <= 6'h00;
      end
    join
    check("set_wins", channel_event_flag_out, 6'h02);
    @(posedge clk_sys_in);
    chan_home_clear_in <= 6'h02;
    @(posedge clk_sys_in);
    chan_home_clear_in <= 6'h00;
    #1;
    check("home_clr", channel_event_flag_out, 6'h00);
    @(posedge clk_sys_in);
    overflow_event_in <= 1'b1;
    @(posedge clk_sys_in);
    overflow_event_in <= 1'b0;
    #1;
    check("ovf_set", counter_overflow_flag_out, 1'b1);
    @(posedge clk_sys_in);
    overflow_home_clear_in <= 1'b1;
    @(posedge clk_sys_in);
    overflow_home_clear_in <= 1'b0;
    #1;
    check("ovf_home_clr", counter_overflow_flag_out, 1'b0);
    // Internal trigger, mask 0101, start and reload
    wr(tfp_pkg::CONFIG_OFFSET, 32'h05850000);
    @(posedge clk_sys_in);
    counter_enable_in <= 1'b1;
    #1;
    check("no_start", count_permit_out, 1'b0);
    @(posedge clk_sys_in);
    chan_pin_in <= 6'h02;
    #1;
    check("unsel", counter_reload_out, 1'b0);
    @(posedge clk_sys_in);
    chan_pin_in <= 6'h06;
    #1;
    check("start", counter_start_out, 1'b1);
    check("reload", counter_reload_out, 1'b1);
    @(posedge clk_sys_in);
    #1;
    check("permit", count_permit_out, 1'b1);
    @(posedge clk_sys_in);
    chan_pin_in <= 6'h02;
    #1;
    check("fall_reload", counter_reload_out, 1'b1);
    check("fall_nostart", counter_start_out, 1'b0);
    @(posedge clk_sys_in);
    mode_pause_in <= 1'b1;
    chan_pin_in <= 6'h03;
    #1;
    check("dbg_ignore", counter_reload_out, 1'b0);
    @(posedge clk_sys_in);
    mode_pause_in <= 1'b0;
    chan_pin_in <= 6'h00;
    counter_enable_in <= 1'b0;
    // Internal pause follows pin level through polarity
    wr(tfp_pkg::CONFIG_OFFSET, 32'h05880000);
    @(posedge clk_sys_in);
    counter_enable_in <= 1'b1;
    chan_pin_in <= 6'h04;
    #1;
    check("pause_int", counter_pause_out, 1'b1);
    check("pause_permit", count_permit_out, 1'b0);
    wr(tfp_pkg::POLARITY_OFFSET, 32'h00000004);
    check("pol_inv_hi", counter_pause_out, 1'b0);
    @(posedge clk_sys_in);
    chan_pin_in <= 6'h00;
    #1;
    check("pol_inv_lo", counter_pause_out, 1'b1);
    wr(tfp_pkg::POLARITY_OFFSET, 32'h00000000);
    @(posedge clk_sys_in);
    counter_enable_in <= 1'b0;
    // External trigger 3, reload on rise, both polarities
    wr(tfp_pkg::CONFIG_OFFSET, 32'h03040000);
    @(posedge clk_sys_in);
    ext_trigger_in <= 16'h0008;
    #1;
    check("ext_rise", counter_reload_out, 1'b1);
    @(posedge clk_sys_in);
    ext_trigger_in <= 16'h0004;
    #1;
    check("ext_fall", counter_reload_out, 1'b0);
    wr(tfp_pkg::CONFIG_OFFSET, 32'h03440000);
    @(posedge clk_sys_in);
    ext_trigger_in <= 16'h0008;
    @(posedge clk_sys_in);
    ext_trigger_in <= 16'h0000;
    #1;
    check("ext_low_act", counter_reload_out, 1'b1);
    wr(tfp_pkg::CONFIG_OFFSET, 32'h03480000);
    check("ext_pause", counter_pause_out, 1'b1);
    stop_test();
  end
endmodule : tb
